// ### verilog/arith_logic_unit_8bit.sv
/*
 * Execution datapath of the 8-bit core: byte arithmetic and logic on
 * register or immediate operands, word add and subtract of an immediate
 * on a register pair, and the status flags.
 * Assumes the decoder supplies operand values already read from the
 * register file, and that the register file takes o_wr as its write port
 * and forwards a pending write to a following read, as for any byte op.
 */
// Notes on behaviour
// - Register add writes destination plus source, plus carry for the carrying form, in one cycle, flags Z C N V H.
// - Word add of an immediate to a register pair writes the pair back in two cycles, flags Z C N V S.
// - Subtract of a register or immediate writes the difference in one cycle, flags Z C N V H.
// - Subtract with carry, register or immediate, also subtracts the carry, one cycle, flags Z C N V H.
// - Word subtract of an immediate from a register pair writes the pair back in two cycles, flags Z C N V S.
// - AND with a register or immediate writes the result in one cycle and changes only Z N V.
// - OR with register or immediate and XOR of two registers write in one cycle and change only Z N V.
// - One's complement gives all-ones minus the value, flags Z C N V; two's complement gives zero minus it, also H.
// - Set-bits ORs an immediate mask into the destination in one cycle, flags Z N V.
// - Clear-bits ANDs the destination with all-ones minus the mask in one cycle, flags Z N V.
`timescale 1ns/1ps
module arith_logic_unit_8bit
    import alu_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Instruction from the decoder.
    input wire instr_type i_instr,
    // Write-back to the register file.
    output wr_type o_wr,
    // Status and handshake.
    output flags_type o_flags,
    output logic o_busy
);

    typedef enum logic {st_idle, st_word_high} state_type;

    ////////////////////////////////////////////////////////////////////////////
    // Per-operation decoding.

    function automatic flags_type op_mask(input op_type op);
        flags_type m;
        m = flags_reset;
        case (op)
            op_add, op_add_carry, op_sub, op_imm_subtract,
            op_reg_subtract_with_carry, op_imm_subtract_with_carry,
            op_twos_complement_op: begin
                m.z = 1'b1;
                m.c = 1'b1;
                m.n = 1'b1;
                m.v = 1'b1;
                m.h = 1'b1;
            end
            op_ones_complement_op: begin
                m.z = 1'b1;
                m.c = 1'b1;
                m.n = 1'b1;
                m.v = 1'b1;
            end
            op_word_add_immediate, op_word_subtract_immediate: begin
                m.z = 1'b1;
                m.c = 1'b1;
                m.n = 1'b1;
                m.v = 1'b1;
                m.s = 1'b1;
            end
            op_none: m = flags_reset;
            default: begin
                m.z = 1'b1;
                m.n = 1'b1;
                m.v = 1'b1;
            end
        endcase
        return m;
    endfunction

    function automatic logic is_word(input op_type op);
        return (op == op_word_add_immediate) || (op == op_word_subtract_immediate);
    endfunction

    function automatic logic is_logic(input op_type op);
        return (op == op_and) || (op == op_imm_bitwise_conjunction) || (op == op_or)
            || (op == op_imm_bitwise_disjunction) || (op == op_bitwise_exclusive_disjunction)
            || (op == op_set_bits_op) || (op == op_clear_bits_op);
    endfunction

    // Flags named in the mask take the new value, the rest hold.
    function automatic flags_type merge(input flags_type old_f, input flags_type new_f,
                                        input flags_type m);
        return (old_f & ~m) | (new_f & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection.

    state_type state_r;
    flags_type flags_r;
    wr_type wr_r;
    logic busy_r;
    logic [4:0] hi_idx_r;
    logic [7:0] hi_data_r;
    flags_type word_flags_r;

    alu_kind_type kind;
    logic [7:0] opa;
    logic [7:0] opb;
    logic cin;
    logic [7:0] byte_result;
    flags_type byte_flags;
    logic [15:0] word_result;
    flags_type word_flags;
    logic accept;

    assign accept = i_instr.valid && (state_r == st_idle);

    always_comb begin
        kind = kind_add;
        opa = i_instr.dst_val;
        opb = i_instr.src_reg;
        cin = 1'b0;
        case (i_instr.op)
            op_add_carry: cin = flags_r.c;
            op_sub: kind = kind_sub;
            op_imm_subtract: begin
                kind = kind_sub;
                opb = i_instr.imm;
            end
            op_reg_subtract_with_carry: begin
                kind = kind_sub;
                cin = flags_r.c;
            end
            op_imm_subtract_with_carry: begin
                kind = kind_sub;
                opb = i_instr.imm;
                cin = flags_r.c;
            end
            op_and: kind = kind_and;
            op_imm_bitwise_conjunction: begin
                kind = kind_and;
                opb = i_instr.imm;
            end
            op_or: kind = kind_or;
            op_imm_bitwise_disjunction, op_set_bits_op: begin
                kind = kind_or;
                opb = i_instr.imm;
            end
            op_bitwise_exclusive_disjunction: kind = kind_xor;
            op_ones_complement_op: begin
                // All-ones minus the value never borrows; carry is forced below.
                kind = kind_sub;
                opa = all_ones;
                opb = i_instr.dst_val;
            end
            op_twos_complement_op: begin
                kind = kind_sub;
                opa = byte_zero;
                opb = i_instr.dst_val;
            end
            op_clear_bits_op: begin
                kind = kind_and;
                opb = all_ones - i_instr.imm;
            end
            default: kind = kind_add;
        endcase
    end

    byte_alu_unit u_byte (
        .i_kind(kind),
        .i_a(opa),
        .i_b(opb),
        .i_cin(cin),
        .o_result(byte_result),
        .o_flags(byte_flags)
    );

    word_alu_unit u_word (
        .i_pair({i_instr.dst_hi_val, i_instr.dst_val}),
        .i_k(i_instr.imm),
        .i_sub(i_instr.op == op_word_subtract_immediate),
        .o_result(word_result),
        .o_flags(word_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing of word operations.

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r <= st_idle;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                st_idle: begin
                    if (accept && is_word(i_instr.op)) begin
                        state_r <= st_word_high;
                        busy_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= st_idle;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // High half and its flags wait here while the low byte is written.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            hi_idx_r <= 5'h00;
            hi_data_r <= byte_zero;
            word_flags_r <= flags_reset;
        end else if (accept && is_word(i_instr.op)) begin
            hi_idx_r <= i_instr.dst_idx + pair_step;
            hi_data_r <= word_result[15:8];
            word_flags_r <= word_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write-back and flags.

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wr_r <= wr_idle;
        end else if (state_r == st_word_high) begin
            wr_r <= '{en: 1'b1, idx: hi_idx_r, data: hi_data_r};
        end else if (accept && is_word(i_instr.op)) begin
            wr_r <= '{en: 1'b1, idx: i_instr.dst_idx, data: word_result[7:0]};
        end else if (accept && (i_instr.op != op_none)) begin
            wr_r <= '{en: 1'b1, idx: i_instr.dst_idx, data: byte_result};
        end else begin
            wr_r <= wr_idle;
        end
    end

    flags_type byte_new;

    always_comb begin
        byte_new = byte_flags;
        // The one's complement always reports a carry out.
        if (i_instr.op == op_ones_complement_op) begin
            byte_new.c = 1'b1;
        end
    end

    // Word flags land with the high byte so they describe the whole pair.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            flags_r <= flags_reset;
        end else if (state_r == st_word_high) begin
            flags_r <= merge(flags_r, word_flags_r, op_mask(op_word_add_immediate));
        end else if (accept && !is_word(i_instr.op)) begin
            flags_r <= merge(flags_r, byte_new, op_mask(i_instr.op));
        end
    end

    assign o_wr = wr_r;
    assign o_flags = flags_r;
    assign o_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    byte_write_next_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && !is_word(i_instr.op) && (i_instr.op != op_none)
        |=> o_wr.en && (o_wr.idx == $past(i_instr.dst_idx)) && !o_busy)
        else $error("byte op did not write back in one cycle");

    add_result_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_add_carry)
        |=> o_wr.data == 8'($past(i_instr.dst_val) + $past(i_instr.src_reg) + {7'h00, $past(flags_r.c)}))
        else $error("add with carry result wrong");

    word_two_cycle_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && is_word(i_instr.op)
        |=> o_busy && o_wr.en ##1 !o_busy && o_wr.en && (o_wr.idx == 5'($past(i_instr.dst_idx, 2) + pair_step)))
        else $error("word op did not write both halves in two cycles");

    word_sub_pair_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_word_subtract_immediate)
        |=> (o_wr.data == $past(word_result[7:0])) ##1 (o_wr.data == $past(word_result[15:8], 2))
            && (o_flags.z == ($past(word_result, 2) == word_zero)))
        else $error("word subtract pair or zero flag wrong");

    sub_borrow_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_sub)
        |=> (o_flags.c == ($past(i_instr.src_reg) > $past(i_instr.dst_val)))
            && (o_wr.data == 8'($past(i_instr.dst_val) - $past(i_instr.src_reg))))
        else $error("subtract borrow or difference wrong");

    logic_keeps_ch_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && is_logic(i_instr.op)
        |=> !o_flags.v && $stable(o_flags.c) && $stable(o_flags.h) && $stable(o_flags.s))
        else $error("logic op touched an unnamed flag");

    com_sets_carry_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_ones_complement_op)
        |=> o_flags.c && (o_wr.data == 8'(all_ones - $past(i_instr.dst_val))))
        else $error("one's complement result or carry wrong");

    clear_bits_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_clear_bits_op)
        |=> (o_wr.data == ($past(i_instr.dst_val) & ~$past(i_instr.imm))) && $stable(o_flags.c))
        else $error("clear-bits result wrong");

    set_bits_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_set_bits_op)
        |=> (o_wr.data == ($past(i_instr.dst_val) | $past(i_instr.imm))) && o_flags.z == (o_wr.data == byte_zero))
        else $error("set-bits result or zero flag wrong");

    sbc_carry_in_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        accept && (i_instr.op == op_imm_subtract_with_carry)
        |=> o_wr.data == 8'($past(i_instr.dst_val) - $past(i_instr.imm) - {7'h00, $past(flags_r.c)}))
        else $error("subtract with carry ignored the carry");

endmodule

// ### include/alu_pkg.sv
/*
 * Shared types and constants of the 8-bit arithmetic and logic datapath:
 * operation codes, flag layout, instruction and write-back carriers.
 * Assumes an instruction decoder that fetches operands from the register
 * file and a register file that accepts one byte write per cycle.
 */
package alu_pkg;

    localparam int byte_w = 8;
    localparam int word_w = 16;
    localparam int idx_w = 5;
    localparam int byte_msb = 7;
    localparam int word_msb = 15;
    localparam int half_msb = 3;
    localparam logic [7:0] all_ones = 8'hff;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [15:0] word_zero = 16'h0000;
    localparam logic [4:0] pair_step = 5'h01;

    typedef enum logic [4:0] {
        op_none,
        op_add,
        op_add_carry,
        op_sub,
        op_imm_subtract,
        op_reg_subtract_with_carry,
        op_imm_subtract_with_carry,
        op_and,
        op_imm_bitwise_conjunction,
        op_or,
        op_imm_bitwise_disjunction,
        op_bitwise_exclusive_disjunction,
        op_ones_complement_op,
        op_twos_complement_op,
        op_set_bits_op,
        op_clear_bits_op,
        op_word_add_immediate,
        op_word_subtract_immediate
    } op_type;

    typedef enum logic [2:0] {
        kind_add,
        kind_sub,
        kind_and,
        kind_or,
        kind_xor
    } alu_kind_type;

    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_type;

    localparam flags_type flags_reset = 6'h00;

    typedef struct packed {
        logic valid;
        op_type op;
        logic [4:0] dst_idx;
        logic [7:0] dst_val;
        logic [7:0] dst_hi_val;
        logic [7:0] src_reg;
        logic [7:0] imm;
    } instr_type;

    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [7:0] data;
    } wr_type;

    localparam wr_type wr_idle = 14'h0000;

endpackage

// ### verilog/byte_alu_unit.sv
/*
 * Combinational byte arithmetic and logic unit with its flag results.
 * Assumes the caller picks operands, carry-in and which flags to keep.
 */
`timescale 1ns/1ps
module byte_alu_unit
    import alu_pkg::*;
(
    // Operation and operands.
    input wire alu_kind_type i_kind,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    // Result and flags.
    output logic [7:0] o_result,
    output flags_type o_flags
);

    logic [8:0] wide;
    logic [4:0] half;
    logic a7;
    logic b7;
    logic r7;

    always_comb begin
        wide = 9'h000;
        half = 5'h00;
        o_flags = flags_reset;
        a7 = i_a[byte_msb];
        b7 = i_b[byte_msb];
        case (i_kind)
            kind_add: begin
                wide = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
                half = {1'b0, i_a[half_msb:0]} + {1'b0, i_b[half_msb:0]} + {4'h0, i_cin};
            end
            kind_sub: begin
                wide = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
                half = {1'b0, i_a[half_msb:0]} - {1'b0, i_b[half_msb:0]} - {4'h0, i_cin};
            end
            kind_and: wide = {1'b0, i_a & i_b};
            kind_or: wide = {1'b0, i_a | i_b};
            default: wide = {1'b0, i_a ^ i_b};
        endcase
        o_result = wide[7:0];
        r7 = wide[byte_msb];
        // Bit 4 of the nibble sum is the carry or borrow out of bit 3.
        o_flags.h = half[4];
        o_flags.c = wide[8];
        o_flags.n = r7;
        o_flags.z = (wide[7:0] == byte_zero);
        if (i_kind == kind_add) begin
            o_flags.v = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
        end else if (i_kind == kind_sub) begin
            o_flags.v = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        end else begin
            o_flags.v = 1'b0;
        end
        o_flags.s = o_flags.n ^ o_flags.v;
    end

endmodule

// ### verilog/word_alu_unit.sv
/*
 * Combinational 16-bit add or subtract of an immediate on a register pair.
 * Assumes the pair arrives as high and low bytes already joined.
 */
`timescale 1ns/1ps
module word_alu_unit
    import alu_pkg::*;
(
    // Operands.
    input wire logic [15:0] i_pair,
    input wire logic [7:0] i_k,
    input wire logic i_sub,
    // Result and flags.
    output logic [15:0] o_result,
    output flags_type o_flags
);

    logic p15;
    logic r15;

    always_comb begin
        o_flags = flags_reset;
        if (i_sub) begin
            o_result = i_pair - {8'h00, i_k};
        end else begin
            o_result = i_pair + {8'h00, i_k};
        end
        p15 = i_pair[word_msb];
        r15 = o_result[word_msb];
        o_flags.n = r15;
        o_flags.z = (o_result == word_zero);
        o_flags.v = i_sub ? (p15 & ~r15) : (~p15 & r15);
        o_flags.c = i_sub ? (r15 & ~p15) : (~r15 & p15);
        o_flags.s = o_flags.n ^ o_flags.v;
    end

endmodule

// ### tb/reg_file_model.sv
/*
 * Behavioural model of the register file that faces the datapath: 32 bytes,
 * one write per cycle from the write-back port, reads with forwarding.
 * Assumes the bench presets registers only while no write is pending.
 */
`timescale 1ns/1ps
module reg_file_model
    import alu_pkg::*;
(
    // Clock.
    input wire logic i_sys_clk,
    // Write-back from the datapath.
    input wire wr_type i_wr
);
    logic [7:0] regs [0:31];

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_sys_clk) begin
        if (i_wr.en) begin
            regs[i_wr.idx] <= i_wr.data;
        end
    end

    // A write still on the port is returned, so back-to-back operations see it.
    function automatic logic [7:0] read_fwd(input logic [4:0] idx);
        return (i_wr.en === 1'b1 && i_wr.idx === idx) ? i_wr.data : regs[idx];
    endfunction
endmodule

// ### tb/tb_top.sv
/*
 * Self-checking bench of the byte and word datapath: issues every operation
 * back to back with boundary operands and checks writes, pairing and flags.
 * Assumes the register file model forwards a pending write to reads.
 */
`timescale 1ns/1ps
module tb_top
    import alu_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    instr_type instr = '0;
    wr_type o_wr;
    flags_type o_flags;
    logic o_busy;
    flags_type exp_f = flags_reset;
    int num_errors = 0;
    int checks_done = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    arith_logic_unit_8bit arith_logic_unit_8bit_i (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_instr(instr),
        .o_wr(o_wr), .o_flags(o_flags), .o_busy(o_busy));

    reg_file_model reg_file_model_i (.i_sys_clk(i_sys_clk), .i_wr(o_wr));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reference result and flags, worked out independently of the design.
    function automatic void expect_op(input op_type op, input logic [7:0] d, hi, s, k,
                                      input flags_type f, output logic [15:0] r, output flags_type g);
        logic [8:0] t;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic [15:0] p;
        g = f;
        r = 16'h0000;
        p = {hi, d};
        a = d;
        b = s;
        cin = 1'b0;
        case (op)
            op_add, op_add_carry: begin
                cin = (op == op_add_carry) ? f.c : 1'b0;
                t = {1'b0, d} + {1'b0, s} + {8'h00, cin};
                r = {8'h00, t[7:0]};
                g.h = (d[3] & s[3]) | (s[3] & ~t[3]) | (~t[3] & d[3]);
                g.v = (d[7] & s[7] & ~t[7]) | (~d[7] & ~s[7] & t[7]);
                g.c = t[8];
            end
            op_sub, op_imm_subtract, op_reg_subtract_with_carry, op_imm_subtract_with_carry,
            op_twos_complement_op: begin
                if (op == op_imm_subtract || op == op_imm_subtract_with_carry) begin
                    b = k;
                end
                if (op == op_reg_subtract_with_carry || op == op_imm_subtract_with_carry) begin
                    cin = f.c;
                end
                if (op == op_twos_complement_op) begin
                    a = 8'h00;
                    b = d;
                end
                t = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                r = {8'h00, t[7:0]};
                g.h = (~a[3] & b[3]) | (b[3] & t[3]) | (t[3] & ~a[3]);
                g.v = (a[7] & ~b[7] & ~t[7]) | (~a[7] & b[7] & t[7]);
                g.c = t[8];
            end
            op_and: r = {8'h00, d & s};
            op_imm_bitwise_conjunction: r = {8'h00, d & k};
            op_clear_bits_op: r = {8'h00, d & (8'hff - k)};
            op_or: r = {8'h00, d | s};
            op_imm_bitwise_disjunction, op_set_bits_op: r = {8'h00, d | k};
            op_bitwise_exclusive_disjunction: r = {8'h00, d ^ s};
            op_ones_complement_op: begin
                r = {8'h00, 8'hff - d};
                g.c = 1'b1;
            end
            op_word_add_immediate: begin
                r = p + {8'h00, k};
                g.v = ~p[15] & r[15];
                g.c = ~r[15] & p[15];
            end
            op_word_subtract_immediate: begin
                r = p - {8'h00, k};
                g.v = p[15] & ~r[15];
                g.c = r[15] & ~p[15];
            end
            default: ;
        endcase
        if (op inside {op_and, op_imm_bitwise_conjunction, op_clear_bits_op, op_or, op_set_bits_op,
                       op_imm_bitwise_disjunction, op_bitwise_exclusive_disjunction,
                       op_ones_complement_op}) begin
            g.v = 1'b0;
        end
        if (op inside {op_word_add_immediate, op_word_subtract_immediate}) begin
            g.z = (r == 16'h0000);
            g.n = r[15];
            g.s = g.n ^ g.v;
        end else if (op != op_none) begin
            g.z = (r[7:0] == 8'h00);
            g.n = r[7];
        end
    endfunction

    // Called just after an edge; leaves a byte operation valid so that the
    // caller can follow it back to back, or must call idle.
    task automatic issue(input op_type op, input logic [4:0] di, input logic [4:0] si, input logic [7:0] k);
        logic [7:0] d;
        logic [7:0] hi;
        logic [7:0] s;
        logic [15:0] r;
        flags_type g;
        d = reg_file_model_i.read_fwd(di);
        hi = reg_file_model_i.read_fwd(di + 5'h01);
        s = reg_file_model_i.read_fwd(si);
        instr = '{1'b1, op, di, d, hi, s, k};
        expect_op(op, d, hi, s, k, exp_f, r, g);
        exp_f = g;
        @(posedge i_sys_clk);
        #1;
        check("write enable", 16'(o_wr.en), 16'(op != op_none));
        if (op != op_none) begin
            check("write index", 16'(o_wr.idx), 16'(di));
            check("low byte", 16'(o_wr.data), {8'h00, r[7:0]});
        end
        if (op inside {op_word_add_immediate, op_word_subtract_immediate}) begin
            check("busy", 16'(o_busy), 16'h0001);
            // Offered while busy: must be dropped.
            instr = '{1'b1, op_ones_complement_op, di, d, hi, s, k};
            @(posedge i_sys_clk);
            #1;
            check("high write", 16'(o_wr.en), 16'h0001);
            check("high index", 16'(o_wr.idx), 16'(5'(di + 5'h01)));
            check("high byte", 16'(o_wr.data), {8'h00, r[15:8]});
            check("busy end", 16'(o_busy), 16'h0000);
        end
        check("flags", 16'(o_flags), 16'(exp_f));
    endtask

    task automatic idle();
        instr.valid = 1'b0;
        @(posedge i_sys_clk);
        #1;
        check("idle write", 16'(o_wr.en), 16'h0000);
        check("idle busy", 16'(o_busy), 16'h0000);
    endtask

    task automatic round(input logic [7:0] d, input logic [7:0] s, input logic [7:0] k);
        reg_file_model_i.regs[4] = d;
        reg_file_model_i.regs[5] = s;
        reg_file_model_i.regs[30] = s;
        reg_file_model_i.regs[31] = d;
        reg_file_model_i.regs[0] = s;
        issue(op_word_add_immediate, 5'd31, 5'd5, k);
        issue(op_add, 5'd4, 5'd5, k);
        issue(op_add_carry, 5'd4, 5'd5, k);
        issue(op_sub, 5'd4, 5'd5, k);
        issue(op_reg_subtract_with_carry, 5'd4, 5'd5, k);
        issue(op_imm_subtract, 5'd4, 5'd5, k);
        issue(op_imm_subtract_with_carry, 5'd4, 5'd5, k);
        issue(op_word_subtract_immediate, 5'd30, 5'd5, k);
        issue(op_and, 5'd4, 5'd5, k);
        issue(op_imm_bitwise_conjunction, 5'd5, 5'd4, k);
        issue(op_or, 5'd4, 5'd5, k);
        issue(op_imm_bitwise_disjunction, 5'd5, 5'd4, k);
        issue(op_bitwise_exclusive_disjunction, 5'd4, 5'd5, k);
        issue(op_none, 5'd4, 5'd5, k);
        issue(op_ones_complement_op, 5'd5, 5'd4, k);
        issue(op_twos_complement_op, 5'd4, 5'd5, k);
        issue(op_set_bits_op, 5'd5, 5'd4, k);
        issue(op_clear_bits_op, 5'd4, 5'd5, k);
        issue(op_word_add_immediate, 5'd4, 5'd5, k);
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 32; i++) begin
            reg_file_model_i.regs[i] = 8'(i * 37);
        end
        repeat (10) @(posedge i_sys_clk);
        #1;
        check("reset flags", 16'(o_flags), 16'(flags_reset));
        check("reset write", 16'(o_wr.en), 16'h0000);
        check("reset busy", 16'(o_busy), 16'h0000);
        i_reset = 1'b0;
        idle();
        round(8'h00, 8'h00, 8'h00);
        round(8'hff, 8'h01, 8'h01);
        round(8'h7f, 8'h01, 8'h80);
        round(8'h80, 8'hff, 8'h0f);
        round(8'h0f, 8'hf1, 8'hff);
        // Reset in mid-run, with a word operation half done, must drop the high write and clear the flags.
        instr = '{1'b1, op_word_add_immediate, 5'd4, 8'hff, 8'hff, 8'h00, 8'h01};
        @(posedge i_sys_clk);
        #1;
        check("word taken", 16'(o_busy), 16'h0001);
        instr.valid = 1'b0;
        i_reset = 1'b1;
        @(posedge i_sys_clk);
        #1;
        check("second reset", 16'(o_flags), 16'(flags_reset));
        check("second reset write", 16'(o_wr.en), 16'h0000);
        check("second reset busy", 16'(o_busy), 16'h0000);
        i_reset = 1'b0;
        exp_f = flags_reset;
        idle();
        round(8'h01, 8'hff, 8'h3f);
        tally_and_finish();
    end

    initial begin
        #1000000;
        num_errors++;
        tally_and_finish();
    end
endmodule
